// *** eid_pkg.sv ***
package eid_pkg;

  // ************************************************************
  // Channel population and register layout
  // ************************************************************

  // Number of external interrupt inputs that are implemented.
  localparam int unsigned EID_NUM_CH = 7;
  // Interrupt number, configuration register and nibble of each channel.
  localparam int unsigned EID_CH_NUM [EID_NUM_CH] = '{0, 1, 2, 4, 5, 7, 8};
  localparam int unsigned EID_CH_REG [EID_NUM_CH] = '{0, 0, 0, 1, 1, 1, 2};
  localparam int unsigned EID_CH_NIB [EID_NUM_CH] = '{0, 1, 2, 0, 1, 3, 0};
  // Each channel owns a nibble: mode in the low three bits, enable on top.
  localparam int unsigned EID_NIB_W = 4;
  localparam int unsigned EID_MODE_W = 3;
  localparam int unsigned EID_EN_POS = 3;
  localparam int unsigned EID_REG_W = 16;
  localparam int unsigned EID_NUM_CFG = 3;

  // Register byte addresses.
  localparam logic [31:0] EID_ADDR_CFG0 = 32'h4000_2420;
  localparam logic [31:0] EID_ADDR_CFG1 = 32'h4000_2424;
  localparam logic [31:0] EID_ADDR_CFG2 = 32'h4000_2428;
  localparam logic [31:0] EID_ADDR_CLR = 32'h4000_2430;
  localparam logic [31:0] EID_ADDR_STAT = 32'h4000_2434;
  localparam logic [31:0] EID_ADDR_ENA = 32'h4000_2438;

  // Writable bits of each register; reserved bits read as zero.
  localparam logic [15:0] EID_CFG_MASK [EID_NUM_CFG] = '{16'h0fff, 16'hf0ff, 16'h000f};
  localparam logic [15:0] EID_IRQ_MASK = 16'h01b7;
  localparam logic [15:0] EID_RESET_VAL = 16'h0000;

  // ************************************************************
  // Detection types and bus answers
  // ************************************************************

  typedef enum logic [2:0] {
    EID_MODE_RISE = 3'h0,
    EID_MODE_FALL = 3'h1,
    EID_MODE_BOTH = 3'h2,
    EID_MODE_HIGH = 3'h3,
    EID_MODE_LOW = 3'h4,
    EID_MODE_FALL_ALT = 3'h5,
    EID_MODE_BOTH_ALT = 3'h6,
    EID_MODE_HIGH_ALT = 3'h7
  } eid_mode_t;

  localparam logic [1:0] EID_RESP_OKAY = 2'h0;
  localparam logic [1:0] EID_RESP_SLVERR = 2'h2;

endpackage

// *** eid_external_interrupt_detect.sv ***
// Contract
// - Seven inputs, each independently enabled and typed.
// - Edge modes give a one-cycle request pulse.
// - Level modes hold request while level persists.
// - Always-on logic; enabled event raises wake.
// - Input path enable gates each pin.
// - Configuration and clear registers reset to zero.
// - Config 0 bit 11 enables interrupt 2.
// - Config 0 bits 10:8 type interrupt 2.
// - Codes 101,110,111 alias 001,010,011.
// - Config 0 bit 7 enables interrupt 1.
// - Registers at 0x420, 0x424, 0x428, 0x430.
// - Writing one clears flag; bit self-clears.
// - Interrupt 0 uses bit 3 and 2:0.
// - Interrupt 1 type in bits 6:4.
// - Interrupts 4,5,7 config 1; 8 config 2.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module eid_external_interrupt_detect #(
  parameter int unsigned N_CH = eid_pkg::EID_NUM_CH
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address and data.
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // External pins and their input path enables.
  input wire logic [eid_pkg::EID_NUM_CH-1:0] pin_in,
  input wire logic [eid_pkg::EID_NUM_CH-1:0] pin_input_path_enable,
  // Requests to the nested vectored irq ctrl, wake and summary interrupt.
  output logic [eid_pkg::EID_NUM_CH-1:0] irq_req,
  output logic wake_req,
  output logic irq
);
  import eid_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_hold, w_hold, wr_fire;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [15:0] cfg_reg [EID_NUM_CFG];
  logic [15:0] clr_reg, ena_reg, status_reg;
  logic [15:0] evt_vec, rd_val;
  logic rd_hit, wr_hit;
  logic [N_CH-1:0] sync1_reg, sync2_reg, prev_reg, evt_ch, req_reg;
  logic wake_reg, irq_reg;

  // The channel tables in the package are fixed at seven entries.
  if (N_CH != EID_NUM_CH) begin : g_bad_ch
    $error("N_CH must equal the channel table size");
  end

  // Byte-lane merge restricted to the implemented bits.
  function automatic logic [15:0] eid_merge(input logic [15:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    return ((old_v & ~lanes) | (new_v[15:0] & lanes)) & mask;
  endfunction

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************

  // Address and data are captured independently; the write happens once both are held.
  assign wr_fire = aw_hold && w_hold && !bvalid_reg;

  // Write address channel; ready comes back only after the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_hold <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      aw_addr_reg <= awaddr;
      aw_hold <= 1'b1;
      awready_reg <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      awready_reg <= !aw_hold && !bvalid_reg;
    end
  end

  // Write data channel, same discipline as the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_hold <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready_reg) begin
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
      w_hold <= 1'b1;
      wready_reg <= 1'b0;
    end else begin
      if (wr_fire) begin
        w_hold <= 1'b0;
      end
      wready_reg <= !w_hold && !bvalid_reg;
    end
  end

  // Status is read-only, so a write to it is answered but has no effect.
  always_comb begin
    case (aw_addr_reg)
      EID_ADDR_CFG0, EID_ADDR_CFG1, EID_ADDR_CFG2: wr_hit = 1'b1;
      EID_ADDR_CLR, EID_ADDR_STAT, EID_ADDR_ENA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response; unmapped addresses get a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= EID_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? EID_RESP_OKAY : EID_RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Configuration registers; reserved bits are masked so they stay zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < EID_NUM_CFG; k++) begin
        cfg_reg[k] <= EID_RESET_VAL;
      end
    end else if (wr_fire) begin
      if (aw_addr_reg == EID_ADDR_CFG0) begin
        cfg_reg[0] <= eid_merge(cfg_reg[0], w_data_reg, w_strb_reg, EID_CFG_MASK[0]);
      end
      if (aw_addr_reg == EID_ADDR_CFG1) begin
        cfg_reg[1] <= eid_merge(cfg_reg[1], w_data_reg, w_strb_reg, EID_CFG_MASK[1]);
      end
      if (aw_addr_reg == EID_ADDR_CFG2) begin
        cfg_reg[2] <= eid_merge(cfg_reg[2], w_data_reg, w_strb_reg, EID_CFG_MASK[2]);
      end
    end
  end

  // Clear register holds a written one for a single cycle, then returns to zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_reg <= EID_RESET_VAL;
    end else if (wr_fire && aw_addr_reg == EID_ADDR_CLR) begin
      clr_reg <= eid_merge(EID_RESET_VAL, w_data_reg, w_strb_reg, EID_IRQ_MASK);
    end else begin
      clr_reg <= EID_RESET_VAL;
    end
  end

  // Enable register gating the summary interrupt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_reg <= EID_RESET_VAL;
    end else if (wr_fire && aw_addr_reg == EID_ADDR_ENA) begin
      ena_reg <= eid_merge(ena_reg, w_data_reg, w_strb_reg, EID_IRQ_MASK);
    end
  end

  // Sticky flags; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= EID_RESET_VAL;
    end else begin
      status_reg <= ((status_reg & ~clr_reg) | evt_vec) & EID_IRQ_MASK;
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************

  // Read decode; the clear register reads back its self-clearing content.
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      EID_ADDR_CFG0: rd_val = cfg_reg[0];
      EID_ADDR_CFG1: rd_val = cfg_reg[1];
      EID_ADDR_CFG2: rd_val = cfg_reg[2];
      EID_ADDR_CLR: rd_val = clr_reg;
      EID_ADDR_STAT: rd_val = status_reg;
      EID_ADDR_ENA: rd_val = ena_reg;
      default: begin
        rd_val = EID_RESET_VAL;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read at a time: address ready drops until the data is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= EID_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rd_val};
      rresp_reg <= rd_hit ? EID_RESP_OKAY : EID_RESP_SLVERR;
    end else begin
      if (rready) begin
        rvalid_reg <= 1'b0;
      end
      arready_reg <= !rvalid_reg || rready;
    end
  end

  // ************************************************************
  // Input synchronisation and detection
  // ************************************************************

  // Pins are gated by their input path before the two-stage synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pin_in & pin_input_path_enable;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // One detector per channel, each reading its own nibble.
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    localparam int unsigned BASE = EID_CH_NIB[i] * EID_NIB_W;
    logic en;
    logic rise, fall;
    eid_mode_t mode;

    assign en = cfg_reg[EID_CH_REG[i]][BASE + EID_EN_POS];
    assign mode = eid_mode_t'(cfg_reg[EID_CH_REG[i]][BASE +: EID_MODE_W]);
    assign rise = sync2_reg[i] && !prev_reg[i];
    assign fall = !sync2_reg[i] && prev_reg[i];

    // Mode decode; aliases share the branch of their base code.
    always_comb begin
      case (mode)
        EID_MODE_RISE: evt_ch[i] = en && rise;
        EID_MODE_FALL, EID_MODE_FALL_ALT: evt_ch[i] = en && fall;
        EID_MODE_BOTH, EID_MODE_BOTH_ALT: evt_ch[i] = en && (rise || fall);
        EID_MODE_HIGH, EID_MODE_HIGH_ALT: evt_ch[i] = en && sync2_reg[i];
        EID_MODE_LOW: evt_ch[i] = en && !sync2_reg[i];
        default: evt_ch[i] = 1'b0;
      endcase
    end

    // The event is judged in the same cycle as the enable, since a write may enable the channel next cycle.
    chk_disabled_no_req: assert property (@(posedge aclk) disable iff (!aresetn)
      !en |-> !evt_ch[i] ##1 !req_reg[i]) else $error("disabled channel requested");
    chk_rise_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && mode == EID_MODE_RISE && rise) ##1 (en && mode == EID_MODE_RISE) |-> req_reg[i] ##1 !req_reg[i])
      else $error("rising edge did not give one pulse");
    chk_fall_alias: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && mode == EID_MODE_FALL_ALT && $fell(sync2_reg[i])) |=> req_reg[i]) else $error("alias fall missed");
    chk_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && mode == EID_MODE_LOW) |=> (req_reg[i] == !$past(sync2_reg[i]))) else $error("low level not followed");
    chk_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      evt_ch[i] |=> status_reg[EID_CH_NUM[i]]) else $error("event lost against clear");
    chk_flag_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
      (clr_reg[EID_CH_NUM[i]] && !evt_ch[i]) |=> !status_reg[EID_CH_NUM[i]]) else $error("flag not cleared");
    chk_sync_latency: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && mode == EID_MODE_HIGH && pin_in[i] && pin_input_path_enable[i]) ##1 (en && mode == EID_MODE_HIGH)
      ##1 (en && mode == EID_MODE_HIGH) |=> req_reg[i]) else $error("high level not seen after sync");
  end

  // Scatter channel events onto their interrupt-number bit positions.
  always_comb begin
    evt_vec = EID_RESET_VAL;
    for (int k = 0; k < N_CH; k++) begin
      evt_vec[EID_CH_NUM[k]] = evt_ch[k];
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Requests, wake and summary interrupt are all registered; no clock gating so
  // detection keeps running while the rest of the device hibernates.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg <= '0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      req_reg <= evt_ch;
      wake_reg <= |evt_ch;
      irq_reg <= |(status_reg & ena_reg);
    end
  end

  chk_clear_self: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_reg != EID_RESET_VAL) |=> (clr_reg == EID_RESET_VAL)) else $error("clear bits stuck");
  // Judged at the first edge after release, so registers never reset yet are not looked at.
  chk_reset_zero: assert property (@(posedge aclk)
    (aresetn && !$past(aresetn)) |-> (cfg_reg[0] == EID_RESET_VAL && cfg_reg[1] == EID_RESET_VAL
    && cfg_reg[2] == EID_RESET_VAL && clr_reg == EID_RESET_VAL)) else $error("registers not zero after reset");
  chk_wake_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (|evt_ch) |=> wake_reg ##1 (wake_reg == $past(|evt_ch))) else $error("wake not raised");

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq_req = req_reg;
  assign wake_req = wake_reg;
  assign irq = irq_reg;

endmodule // eid_external_interrupt_detect

// *** eid_irq_ctrl_model.sv ***
`timescale 1ns/10ps
module eid_irq_ctrl_model (
  // Clock.
  input wire logic aclk,
  // Requests arriving from the detector.
  input wire logic [eid_pkg::EID_NUM_CH-1:0] irq_req,
  input wire logic wake_req,
  // Observation control from the bench.
  input wire logic [2:0] sel,
  input wire logic count_en,
  input wire logic count_zero,
  output logic [7:0] req_hits,
  output logic [7:0] wake_hits
);
  import eid_pkg::*;

  // Count request cycles of one line, so a pulse counts once and a level once per cycle it stands.
  always_ff @(posedge aclk) begin
    if (count_zero) begin
      req_hits <= 8'h00;
      wake_hits <= 8'h00;
    end else if (count_en) begin
      req_hits <= req_hits + {7'h00, irq_req[sel]};
      wake_hits <= wake_hits + {7'h00, wake_req};
    end
  end
endmodule  // eid_irq_ctrl_model

// *** test_external_interrupt_detect.sv ***
`timescale 1ns/10ps
module test_external_interrupt_detect;
  import eid_pkg::*;
  typedef struct packed {logic [2:0] ch; logic [3:0] nib; logic path; logic [7:0] hits;} eid_row_t;
  // Nibble is enable over mode; hits is the request cycles in a window with the pin high for six cycles.
  localparam eid_row_t ROWS [10] = '{'{3'h0, 4'h8, 1'b1, 8'h01}, '{3'h1, 4'h9, 1'b1, 8'h01},
    '{3'h2, 4'ha, 1'b1, 8'h02}, '{3'h3, 4'hb, 1'b1, 8'h06}, '{3'h4, 4'hc, 1'b1, 8'h0a},
    '{3'h5, 4'hd, 1'b1, 8'h01}, '{3'h6, 4'he, 1'b1, 8'h02}, '{3'h0, 4'hf, 1'b1, 8'h06},
    '{3'h1, 4'h3, 1'b1, 8'h00}, '{3'h2, 4'h8, 1'b0, 8'h00}};
  localparam logic [31:0] ADDRS [6] = '{EID_ADDR_CFG0, EID_ADDR_CFG1, EID_ADDR_CFG2, EID_ADDR_CLR,
    EID_ADDR_STAT, EID_ADDR_ENA};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic wake_req, irq, count_en, count_zero;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp, rs;
  logic [EID_NUM_CH-1:0] pin_in, pin_input_path_enable, irq_req;
  logic [2:0] sel;
  logic [7:0] req_hits, wake_hits;
  int err_count, check_count;

  eid_external_interrupt_detect dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
    .pin_input_path_enable(pin_input_path_enable), .irq_req(irq_req), .wake_req(wake_req), .irq(irq));
  eid_irq_ctrl_model model (.aclk(aclk), .irq_req(irq_req), .wake_req(wake_req), .sel(sel),
    .count_en(count_en), .count_zero(count_zero), .req_hits(req_hits), .wake_hits(wake_hits));

  // ************************************************************
  // Shared tasks
  // ************************************************************

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshakes are judged at the falling edge, where the values the next rising edge samples are settled.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar_ok, r_ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check(what, d, exp);
    check({what, " resp"}, 32'(r), 32'(er));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and sequence
  // ************************************************************

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // The whole sequence needs well under a thousand cycles; twenty thousand means a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, count_en, count_zero} = '0;
    {awaddr, wdata, araddr} = '0;
    pin_in = '0;
    pin_input_path_enable = '1;
    sel = 3'h0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("req after reset", 32'(irq_req), 32'h0);
    foreach (ADDRS[k]) rd_chk("reset value", ADDRS[k], 32'h0, EID_RESP_OKAY);
    // Reserved bits of the configuration registers read as zero.
    for (int k = 0; k < 3; k++) begin
      axi_wr(EID_ADDR_CFG0 + 32'(4 * k), 32'hffff_ffff, rs);
      rd_chk("cfg fields", EID_ADDR_CFG0 + 32'(4 * k), {16'h0, EID_CFG_MASK[k]}, EID_RESP_OKAY);
    end
    // Table rows: one channel configured, all others cleared, then a six-cycle high pulse on its pin.
    foreach (ROWS[i]) begin
      pin_in <= '0;
      pin_input_path_enable <= {EID_NUM_CH{ROWS[i].path}};
      sel <= ROWS[i].ch;
      for (int k = 0; k < 3; k++) begin
        axi_wr(EID_ADDR_CFG0 + 32'(4 * k), (k == EID_CH_REG[ROWS[i].ch]) ?
          (32'(ROWS[i].nib) << (EID_NIB_W * EID_CH_NIB[ROWS[i].ch])) : 32'h0, rs);
      end
      repeat (8) @(posedge aclk);
      count_zero <= 1'b1;
      @(posedge aclk);
      count_zero <= 1'b0;
      count_en <= 1'b1;
      pin_in <= 7'h01 << ROWS[i].ch;
      repeat (6) @(posedge aclk);
      pin_in <= '0;
      repeat (10) @(posedge aclk);
      count_en <= 1'b0;
      repeat (2) @(posedge aclk);
      check("request cycles", 32'(req_hits), 32'(ROWS[i].hits));
      check("wake cycles", 32'(wake_hits), 32'(ROWS[i].hits));
    end
    // Sticky status, enable masking and the self-clearing clear register.
    pin_input_path_enable <= '1;
    axi_wr(EID_ADDR_CFG0, 32'h0000_0008, rs);
    check("mapped write", 32'(rs), 32'(EID_RESP_OKAY));
    axi_wr(EID_ADDR_CLR, {16'h0, EID_IRQ_MASK}, rs);
    axi_wr(EID_ADDR_ENA, 32'h0000_0001, rs);
    repeat (3) @(posedge aclk);
    rd_chk("status idle", EID_ADDR_STAT, 32'h0, EID_RESP_OKAY);
    pin_in <= 7'h01;
    repeat (4) @(posedge aclk);
    pin_in <= '0;
    repeat (6) @(posedge aclk);
    rd_chk("status set", EID_ADDR_STAT, 32'h1, EID_RESP_OKAY);
    check("irq set", 32'(irq), 32'h1);
    axi_wr(EID_ADDR_ENA, 32'h0, rs);
    repeat (2) @(posedge aclk);
    check("irq masked", 32'(irq), 32'h0);
    axi_wr(EID_ADDR_ENA, 32'h1, rs);
    repeat (2) @(posedge aclk);
    check("irq unmasked", 32'(irq), 32'h1);
    axi_wr(EID_ADDR_CLR, 32'h1, rs);
    repeat (3) @(posedge aclk);
    rd_chk("status cleared", EID_ADDR_STAT, 32'h0, EID_RESP_OKAY);
    check("irq cleared", 32'(irq), 32'h0);
    rd_chk("clear reg", EID_ADDR_CLR, 32'h0, EID_RESP_OKAY);
    // An unmapped word is refused in both directions.
    rd_chk("unmapped read", 32'h4000_243c, 32'h0, EID_RESP_SLVERR);
    axi_wr(32'h4000_243c, 32'h1, rs);
    check("unmapped write", 32'(rs), 32'(EID_RESP_SLVERR));
    // A second reset in mid-run returns the configuration to zero.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("cfg after reset", EID_ADDR_CFG0, 32'h0, EID_RESP_OKAY);
    close_out();
  end
endmodule  // test_external_interrupt_detect
